//--- rtl/ors_origin_return_sequencer.sv
// origin return sequencer with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module ors_origin_return_sequencer
    import ors_pkg::*;
#(
    parameter int PULSE_W = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    input  wire logic               clk_en,
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    output logic [1:0]              avs_response,
    input  wire logic               servo_enable,
    input  wire logic               internal_pos_mode,
    input  wire logic               home_start_input,
    input  wire logic               forward_limit_input,
    input  wire logic               reverse_limit_input,
    input  wire logic               home_sensor_input,
    input  wire logic               encoder_zero,
    input  wire logic               motion_stopped,
    input  wire logic               at_origin,
    output ors_motion_t             motion,
    output logic                    pos_load,
    output logic signed [15:0]      pos_load_turns,
    output logic signed [PULSE_W-1:0] pos_load_pulses,
    output logic                    home_done,
    output logic                    limit_alarm,
    output logic                    limit_warning
);

    typedef struct packed {
        ors_cfg_t            cfg;
        logic [10:0]         fast;
        logic [10:0]         slow;
        logic signed [15:0]  turns;
        logic [PULSE_W-1:0]  pulses;
        ors_state_t          st;
        logic                auto_used;
        logic                start_prev;
        logic                fwd_prev;
        logic                rev_prev;
        logic                sens_prev;
        logic                done;
        logic                alarm;
        logic                warn;
        logic                load;
        logic                ack;
        logic [31:0]         rdata;
        logic [1:0]          resp;
        ors_motion_t         mot;
    } ors_regs_t;

    ors_regs_t r_q;
    ors_regs_t r_d;

    function automatic logic [10:0] clamp_spd(input logic [10:0] v,
                                              input logic [10:0] lo,
                                              input logic [10:0] hi);
        clamp_spd = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic en);
        merge_byte = en ? new_v : old_v;
    endfunction

    logic [31:0] wword;
    logic [31:0] cur_word;
    logic        trig_start;
    logic        fwd_rise;
    logic        rev_rise;
    logic        sens_rise;
    logic        coarse_hit;
    logic        search_rev;
    logic signed [15:0] t_in;

    always_comb begin
        case (avs_address)
            ORS_OFS_SEL: cur_word = {16'h0000, 3'b000, r_q.cfg.stop, 2'b00,
                                    r_q.cfg.trig, 2'b00, r_q.cfg.short_mv, 1'b0,
                                    r_q.cfg.det};
            ORS_OFS_SPEED: cur_word = {5'h00, r_q.slow, 5'h00, r_q.fast};
            ORS_OFS_OFFSET: cur_word = {r_q.pulses[15:0], r_q.turns};
            default: cur_word = 32'h0000_0000;
        endcase
        for (int i = 0; i < 4; i++) begin
            wword[i*8 +: 8] = merge_byte(cur_word[i*8 +: 8], avs_writedata[i*8 +: 8],
                                         avs_byteenable[i]);
        end
    end

    always_comb begin
        fwd_rise  = forward_limit_input & ~r_q.fwd_prev;
        rev_rise  = reverse_limit_input & ~r_q.rev_prev;
        sens_rise = home_sensor_input & ~r_q.sens_prev;
        search_rev = r_q.cfg.det[0];
        case (r_q.cfg.det)
            3'd0: coarse_hit = forward_limit_input;
            3'd1: coarse_hit = reverse_limit_input;
            3'd2, 3'd3: coarse_hit = sens_rise;
            default: coarse_hit = encoder_zero;
        endcase
        trig_start = 1'b0;
        if (servo_enable && internal_pos_mode && r_q.st == ORS_IDLE) begin
            case (r_q.cfg.trig)
                2'd1: trig_start = ~r_q.auto_used;
                2'd2: trig_start = home_start_input & ~r_q.start_prev;
                default: trig_start = 1'b0;
            endcase
        end
    end

    always_comb begin
        r_d = r_q;
        r_d.load = 1'b0;
        r_d.ack  = 1'b0;
        r_d.start_prev = home_start_input;
        r_d.fwd_prev   = forward_limit_input;
        r_d.rev_prev   = reverse_limit_input;
        r_d.sens_prev  = home_sensor_input;
        t_in = $signed(wword[15:0]);

        // register slave: one wait cycle, then answer
        if ((avs_read || avs_write) && !r_q.ack) begin
            r_d.ack  = 1'b1;
            r_d.resp = (avs_address[1:0] != 2'b00) ? 2'b10 : 2'b00;
            r_d.rdata = (avs_address == ORS_OFS_STATUS)
                ? {25'h0, r_q.warn, r_q.alarm, r_q.done, 1'b0, r_q.st}
                : cur_word;
        end

        // write lands on the edge that sees waitrequest low
        if (avs_write && r_q.ack) begin
            case (avs_address)
                ORS_OFS_SEL: begin
                    if (wword[2:0] <= ORS_DET_MAX) r_d.cfg.det = wword[2:0];
                    if (wword[5:4] <= ORS_SHORT_MAX) r_d.cfg.short_mv = wword[5:4];
                    if (wword[9:8] <= ORS_TRIG_MAX) r_d.cfg.trig = wword[9:8];
                    r_d.cfg.stop = wword[ORS_SEL_STOP_LSB];
                end
                ORS_OFS_SPEED: begin
                    r_d.fast = clamp_spd(wword[10:0], ORS_FAST_MIN, ORS_FAST_MAX);
                    r_d.slow = clamp_spd(wword[ORS_SPD_SLOW_LSB +: 11],
                                         ORS_SLOW_MIN, ORS_SLOW_MAX);
                end
                ORS_OFS_OFFSET: begin
                    if (t_in <= ORS_TURNS_MAX && t_in >= ORS_TURNS_MIN)
                        r_d.turns = t_in;
                    r_d.pulses = PULSE_W'(wword[ORS_OFF_PULSE_LSB +: 16]);
                end
                ORS_OFS_STATUS: begin
                    if (wword[5] && !(limit_evt_alarm())) r_d.alarm = 1'b0;
                    if (wword[6] && !(limit_evt_warn())) r_d.warn = 1'b0;
                end
                default: ;
            endcase
        end

        // limit roles after homing; set wins over software clear
        if (r_q.done && r_q.st == ORS_IDLE) begin
            if (r_q.cfg.det == 3'd0 && fwd_rise) r_d.alarm = 1'b1;
            if (r_q.cfg.det == 3'd1 && rev_rise) r_d.warn = 1'b1;
        end

        case (r_q.st)
            ORS_IDLE: begin
                r_d.mot.run = 1'b0;
                r_d.mot.decel = 1'b0;
                if (trig_start) begin
                    r_d.auto_used = 1'b1;
                    r_d.done = 1'b0;
                    r_d.st = ORS_COARSE;
                    r_d.mot.run = 1'b1;
                    r_d.mot.dir_rev = search_rev;
                    r_d.mot.speed = r_q.fast;
                end
            end
            ORS_COARSE: begin
                if (coarse_hit) begin
                    if (r_q.cfg.det >= 3'd4 || (r_q.cfg.short_mv == 2'd2 && r_q.cfg.det >= 3'd2)) begin
                        r_d.st = ORS_DECEL;
                        r_d.mot.decel = 1'b1;
                        r_d.load = 1'b1;
                    end else begin
                        r_d.st = ORS_FINE;
                        r_d.mot.speed = r_q.slow;
                        if (r_q.cfg.short_mv == 2'd0)
                            r_d.mot.dir_rev = ~r_q.mot.dir_rev;
                        else
                            r_d.mot.dir_rev = r_q.mot.dir_rev;
                    end
                end
            end
            ORS_FINE: begin
                if (encoder_zero) begin
                    r_d.st = ORS_DECEL;
                    r_d.mot.decel = 1'b1;
                    r_d.load = 1'b1;
                end
            end
            ORS_DECEL: begin
                if (motion_stopped) begin
                    if (r_q.cfg.stop == 1'b0) begin
                        r_d.st = ORS_PULLBACK;
                        r_d.mot.decel = 1'b0;
                        r_d.mot.speed = r_q.slow;
                        r_d.mot.dir_rev = ~r_q.mot.dir_rev;
                    end else begin
                        r_d.st = ORS_IDLE;
                        r_d.mot.run = 1'b0;
                        r_d.done = 1'b1;
                    end
                end
            end
            ORS_PULLBACK: begin
                if (at_origin) begin
                    r_d.st = ORS_IDLE;
                    r_d.mot.run = 1'b0;
                    r_d.done = 1'b1;
                end
            end
            default: r_d.st = ORS_IDLE;
        endcase

        if (!internal_pos_mode || !servo_enable) begin
            r_d.st = ORS_IDLE;
            r_d.mot.run = 1'b0;
            r_d.mot.decel = 1'b0;
        end
    end

    function automatic logic limit_evt_alarm();
        limit_evt_alarm = r_q.done && r_q.cfg.det == 3'd0 && forward_limit_input
                          && !r_q.fwd_prev;
    endfunction

    function automatic logic limit_evt_warn();
        limit_evt_warn = r_q.done && r_q.cfg.det == 3'd1 && reverse_limit_input
                         && !r_q.rev_prev;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            r_q <= '0;
            r_q.fast <= ORS_FAST_RST;
            r_q.slow <= ORS_SLOW_RST;
            r_q.st <= ORS_IDLE;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !r_q.ack;
    assign avs_readdata    = r_q.rdata;
    assign avs_response    = r_q.resp;
    assign motion          = r_q.mot;
    assign pos_load        = r_q.load;
    assign pos_load_turns  = r_q.turns;
    assign pos_load_pulses = r_q.pulses;
    assign home_done       = r_q.done;
    assign limit_alarm     = r_q.alarm;
    assign limit_warning   = r_q.warn;

endmodule // ors_origin_return_sequencer
`default_nettype wire

//--- rtl/ors_pkg.sv
// package of constants and types for the origin return sequencer
//
// Overview of operation
// - trigger mode 0: homing never starts, whatever else is set
// - trigger mode 1: home once automatically at first servo enable after power-up
// - trigger mode 2: home-start input rising edge starts homing whenever enabled and idle
// - detector 0: forward search on forward limit; afterwards its activation raises alarm
// - detector 1: reverse search on reverse limit; afterwards its activation raises warning
// - detector 2: forward search using home sensor as reference
// - detector 3: reverse search using home sensor as reference
// - detector 4/5: search encoder zero directly, forward 4, reverse 5
// - short-move 0: reverse at slow speed to nearest encoder zero as origin
// - short-move 1: continue in the search direction at slow speed to nearest encoder zero
// - short-move 2: with detectors 2-5, sensor rising edge or encoder zero is origin, then decelerate; detectors 0/1 act as short-move 1
// - stop mode 0: decelerate, then return to origin at slow speed
// - stop mode 1: decelerate and stop, overshoot left uncorrected
// - fast speed accepts 1 to 2000 r/min, default 1000
// - slow speed accepts 1 to 500 r/min, default 50
// - offset turns within +/-30000, pulses taken as written with no range check, default 0
// - homing operates only in internal position command mode
// - selector ranges 0-5, 0-2, 0-2, 0-1, all default 0
package ors_pkg;

    // register byte offsets
    localparam logic [3:0] ORS_OFS_SEL    = 4'h0;
    localparam logic [3:0] ORS_OFS_SPEED  = 4'h4;
    localparam logic [3:0] ORS_OFS_OFFSET = 4'h8;
    localparam logic [3:0] ORS_OFS_STATUS = 4'hc;

    // field positions in the selector, speed and offset registers
    localparam int ORS_SEL_DET_LSB  = 0;
    localparam int ORS_SEL_SHORT_LSB = 4;
    localparam int ORS_SEL_TRIG_LSB = 8;
    localparam int ORS_SEL_STOP_LSB = 12;
    localparam int ORS_SPD_SLOW_LSB = 16;
    localparam int ORS_OFF_PULSE_LSB = 16;

    // limits and reset values
    localparam logic [2:0]  ORS_DET_MAX     = 3'h5;
    localparam logic [1:0]  ORS_SHORT_MAX   = 2'h2;
    localparam logic [1:0]  ORS_TRIG_MAX    = 2'h2;
    localparam logic [10:0] ORS_FAST_MIN    = 11'h001;
    localparam logic [10:0] ORS_FAST_MAX    = 11'h7d0;
    localparam logic [10:0] ORS_FAST_RST    = 11'h3e8;
    localparam logic [10:0] ORS_SLOW_MIN    = 11'h001;
    localparam logic [10:0] ORS_SLOW_MAX    = 11'h1f4;
    localparam logic [10:0] ORS_SLOW_RST    = 11'h032;
    localparam logic signed [15:0] ORS_TURNS_MAX = 16'sh7530;
    localparam logic signed [15:0] ORS_TURNS_MIN = -16'sh7530;

    typedef enum logic [2:0] {
        ORS_IDLE, ORS_COARSE, ORS_FINE, ORS_DECEL, ORS_PULLBACK
    } ors_state_t;

    typedef struct packed {
        logic [2:0] det;
        logic [1:0] short_mv;
        logic [1:0] trig;
        logic       stop;
    } ors_cfg_t;

    typedef struct packed {
        logic        run;
        logic        dir_rev;
        logic [10:0] speed;
        logic        decel;
    } ors_motion_t;

endpackage

//--- tb/ors_chk.sv
// port checker for the origin return sequencer
`timescale 1ns/1ps
`default_nettype none
module ors_chk
    import ors_pkg::*;
#(
    parameter int PULSE_W = 16
) (
    input wire logic                      ref_clk,
    input wire logic                      rst_b,
    input wire logic                      clk_en,
    input wire logic [3:0]                avs_address,
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic [31:0]               avs_writedata,
    input wire logic                      avs_waitrequest,
    input wire logic                      servo_enable,
    input wire logic                      internal_pos_mode,
    input wire logic                      forward_limit_input,
    input wire logic                      reverse_limit_input,
    input wire logic                      motion_stopped,
    input wire ors_motion_t               motion,
    input wire logic                      pos_load,
    input wire logic signed [15:0]        pos_load_turns,
    input wire logic signed [PULSE_W-1:0] pos_load_pulses,
    input wire logic                      home_done,
    input wire logic                      limit_alarm,
    input wire logic                      limit_warning
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [31:0] sel_q;
    logic [31:0] spd_q;
    logic [31:0] off_q;
    wire logic   wr_ok = avs_write && !avs_waitrequest && clk_en;
    wire logic [31:0] wd = avs_writedata;
    function automatic logic [10:0] lim(input logic [10:0] v, input logic [10:0] lo,
                                        input logic [10:0] hi);
        lim = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    // shadow of accepted register fields, field by field
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sel_q <= 32'h0;
            spd_q <= 32'h003203e8;
            off_q <= 32'h0;
        end else if (wr_ok) begin
            if (avs_address == ORS_OFS_SEL) begin
                if (wd[2:0] <= ORS_DET_MAX) sel_q[2:0] <= wd[2:0];
                if (wd[5:4] <= ORS_SHORT_MAX) sel_q[5:4] <= wd[5:4];
                if (wd[9:8] <= ORS_TRIG_MAX) sel_q[9:8] <= wd[9:8];
                sel_q[12] <= wd[12];
            end
            if (avs_address == ORS_OFS_SPEED) begin
                spd_q[10:0] <= lim(wd[10:0], ORS_FAST_MIN, ORS_FAST_MAX);
                spd_q[26:16] <= lim(wd[26:16], ORS_SLOW_MIN, ORS_SLOW_MAX);
            end
            if (avs_address == ORS_OFS_OFFSET) begin
                if ($signed(wd[15:0]) <= ORS_TURNS_MAX && $signed(wd[15:0]) >= ORS_TURNS_MIN)
                    off_q[15:0] <= wd[15:0];
                off_q[31:16] <= wd[31:16];
            end
        end
    end
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
        |=> !avs_waitrequest) else $error("bus answer late");
    trig_off_a: assert property (sel_q[9:8] == 2'h0 && !motion.run |=> !motion.run)
        else $error("homing started while disabled");
    pos_mode_a: assert property (!(internal_pos_mode && servo_enable)
        |=> ##[0:1] !motion.run) else $error("homing outside position mode");
    start_dir_a: assert property ($rose(motion.run)
        && !$past(motion.decel) |-> motion.dir_rev == sel_q[0] && motion.speed == spd_q[10:0])
        else $error("bad start");
    done_run_a: assert property (motion.run |-> !home_done)
        else $error("done while moving");
    load_val_a: assert property (pos_load |-> pos_load_turns == off_q[15:0]
        && pos_load_pulses == off_q[16 +: PULSE_W] ##1 !pos_load) else $error("bad load");
    load_stop_a: assert property (pos_load |-> ##[0:1] motion.decel)
        else $error("no decel at origin");
    stop_keep_a: assert property (motion.decel && motion_stopped && sel_q[12]
        |=> home_done && !motion.run) else $error("stop mode one moved on");
    pull_back_a: assert property (motion.decel && motion_stopped && !sel_q[12]
        |=> motion.run && !motion.decel && motion.speed == spd_q[26:16]) else $error("no pullback");
    alarm_set_a: assert property (home_done && sel_q[2:0] == 3'h0
        && $rose(forward_limit_input) |-> ##[1:3] limit_alarm) else $error("no limit alarm");
    warn_set_a: assert property (home_done && sel_q[2:0] == 3'h1
        && $rose(reverse_limit_input) |-> ##[1:3] limit_warning) else $error("no limit warning");
    done_c: cover property ($rose(home_done));
    pull_c: cover property (motion.decel && motion_stopped && !sel_q[12]);
    alarm_c: cover property ($rose(limit_alarm));
endmodule // ors_chk
bind ors_origin_return_sequencer ors_chk #(.PULSE_W(PULSE_W)) ors_chk_inst (.ref_clk, .rst_b,
    .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .servo_enable,
    .internal_pos_mode, .forward_limit_input, .reverse_limit_input, .motion_stopped, .motion,
    .pos_load, .pos_load_turns, .pos_load_pulses, .home_done, .limit_alarm, .limit_warning);
`default_nettype wire

//--- tb/ors_partner.sv
// model of limit switches, home sensor, encoder and motion profile
`timescale 1ns/1ps
`default_nettype none
module ors_partner
    import ors_pkg::*;
(
    input  wire ors_motion_t motion,
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire logic        lim_poke,
    output logic             fwd_lim,
    output logic             rev_lim,
    output logic             sensor,
    output logic             enc_zero,
    output logic             stopped,
    output logic             origin
);
    logic [7:0] cnt_q;
    logic [1:0] dcnt_q;
    logic       dir_q;
    wire logic  moving = motion.run && !motion.decel;
    wire logic  hit = moving && cnt_q >= (slow ? 8'h28 : 8'h0a);
    // travel distance since start, reversal or deceleration
    always_ff @(posedge ref_clk) begin
        dir_q <= motion.dir_rev;
        if (!moving || motion.dir_rev != dir_q) cnt_q <= 8'h00;
        else if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
        if (!motion.decel) dcnt_q <= 2'h0;
        else if (dcnt_q != 2'h3) dcnt_q <= dcnt_q + 2'h1;
    end
    assign fwd_lim = lim_poke || (hit && !motion.dir_rev);
    assign rev_lim = lim_poke || (hit && motion.dir_rev);
    assign sensor = hit;
    assign enc_zero = moving && cnt_q[2:0] == 3'h7;
    assign stopped = motion.decel && dcnt_q == 2'h3;
    assign origin = moving && cnt_q == 8'h05;
endmodule // ors_partner
`default_nettype wire

//--- tb/ors_origin_return_sequencer_tb.sv
// self-checking bench for the origin return sequencer
`timescale 1ns/1ps
`default_nettype none
module ors_origin_return_sequencer_tb
    import ors_pkg::*;
;
    logic ref_clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, servo = 1'b0, posm = 1'b1;
    logic start = 1'b0, slow = 1'b0, poke = 1'b0, run_d = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] resp, sm;
    logic wait_r, fl, rl, hs, ez, ms, ao, pl, done, alarm, warn;
    logic signed [15:0] lt, lp, t, p;
    ors_motion_t motion;
    logic [33:0] exp_q[$], ld_q[$];
    int err_total = 0, check_count = 0, runs = 0;
    ors_origin_return_sequencer #(.PULSE_W(16)) ors_origin_return_sequencer_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .avs_response(resp), .servo_enable(servo),
        .internal_pos_mode(posm), .home_start_input(start), .forward_limit_input(fl),
        .reverse_limit_input(rl), .home_sensor_input(hs), .encoder_zero(ez),
        .motion_stopped(ms), .at_origin(ao), .motion(motion), .pos_load(pl),
        .pos_load_turns(lt), .pos_load_pulses(lp), .home_done(done), .limit_alarm(alarm),
        .limit_warning(warn));
    ors_partner ors_partner_inst (.motion(motion), .ref_clk(ref_clk), .slow(slow),
        .lim_poke(poke), .fwd_lim(fl), .rev_lim(rl), .sensor(hs), .enc_zero(ez),
        .stopped(ms), .origin(ao));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge ref_clk); while (wait_r !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdx(input logic [3:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic press();
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // read answers against notes, start counter
    always @(posedge ref_clk) begin
        run_d <= motion.run;
        if (motion.run === 1'b1 && run_d === 1'b0) runs++;
        if (rd && wait_r === 1'b0) chk("read", {resp, rdata}, exp_q.pop_front());
        if (pl === 1'b1) chk("load", {2'b00, lp, lt}, ld_q.pop_front());
    end
    initial begin
        #400000;
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(79));
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdx(ORS_OFS_SEL, 34'h0);
        rdx(ORS_OFS_SPEED, 34'h0003203e8);
        rdx(ORS_OFS_OFFSET, 34'h0);
        bus(1'b1, ORS_OFS_SEL, 32'h00000124);
        ld_q.push_back(34'h0);
        servo <= 1'b1;
        repeat (3) @(posedge ref_clk);
        while (done !== 1'b1) @(posedge ref_clk);
        rdx(ORS_OFS_STATUS, 34'h10);
        servo <= 1'b0;
        repeat (5) @(posedge ref_clk);
        servo <= 1'b1;
        repeat (100) @(posedge ref_clk);
        chk("starts", runs, 34'h1);
        $display("test power-up homing done");
        bus(1'b1, ORS_OFS_SEL, 32'h00000007);
        rdx(ORS_OFS_SEL, 34'h004);
        bus(1'b1, ORS_OFS_SPEED, 32'h000007ff);
        rdx(ORS_OFS_SPEED, 34'h000107d0);
        bus(1'b1, ORS_OFS_SPEED, 32'h01f50000);
        rdx(ORS_OFS_SPEED, 34'h01f40001);
        bus(1'b1, ORS_OFS_OFFSET, 32'h00007531);
        rdx(ORS_OFS_OFFSET, 34'h0);
        rdx(4'h1, {2'b10, 32'h0});
        press();
        chk("starts", runs, 34'h1);
        bus(1'b1, ORS_OFS_SEL, 32'h00000204);
        posm <= 1'b0;
        press();
        chk("starts", runs, 34'h1);
        posm <= 1'b1;
        bus(1'b1, ORS_OFS_SPEED, {5'h0, 11'(1 + $urandom % 500), 5'h0, 11'(1 + $urandom % 2000)});
        $display("test refusals done");
        for (int d = 0; d < 6; d++) begin
            sm = (d < 2) ? 2'h0 : (d < 4) ? 2'($urandom % 3) : 2'h2;
            t = 16'($urandom % 60001) - 16'sd30000;
            p = 16'($urandom);
            ld_q.push_back({2'b00, p, t});
            bus(1'b1, ORS_OFS_OFFSET, {p, t});
            bus(1'b1, ORS_OFS_SEL, {19'h0, 1'($urandom), 4'h2, 2'h0, sm, 1'b0, 3'(d)});
            slow <= 1'($urandom);
            press();
            while (done !== 1'b1) @(posedge ref_clk);
            rdx(ORS_OFS_STATUS, 34'h10);
            if (d < 2) begin
                poke <= 1'b1;
                repeat (4) @(posedge ref_clk);
                poke <= 1'b0;
                rdx(ORS_OFS_STATUS, (d == 0) ? 34'h30 : 34'h50);
                bus(1'b1, ORS_OFS_STATUS, 32'h60);
                rdx(ORS_OFS_STATUS, 34'h10);
            end
            $display("test detector %0d done", d);
        end
        chk("starts", runs, 34'h7);
        chk("loads left", ld_q.size(), 34'h0);
        conclude();
    end
endmodule // ors_origin_return_sequencer_tb
`default_nettype wire
